// ===== rtl/diag_access.sv
// Diagnostic access unit: reads and writes branch buffer, instruction cache and
// data cache arrays entry by entry for privileged diagnostic instructions.
// Assumes the decoder presents one instruction per valid cycle with the base and
// source general register values, and merges rsp.data under rsp.mask into the
// destination register when rsp.valid is high and rsp.trap is low.
`timescale 1ns/100ps
`default_nettype none

module diag_access #(
  parameter int BTB_SETS = 4,
  parameter int BTB_ENTRIES = 64,
  parameter int IC_LINES = 256,
  parameter int IC_WORDS = 4,
  parameter int DC_SETS = 4,
  parameter int DC_ENTRIES = 64,
  parameter int DC_WORDS = 4
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Decoder request and register file answer.
  input wire diag_pkg::cmd_t cmd,
  output diag_pkg::rsp_t rsp,
  // Software register port.
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Interrupt.
  output logic irq
);

  localparam int BE_W = $clog2(BTB_ENTRIES);
  localparam int BS_W = $clog2(BTB_SETS);
  localparam int IL_W = $clog2(IC_LINES);
  localparam int IW_W = $clog2(IC_WORDS);
  localparam int DE_W = $clog2(DC_ENTRIES);
  localparam int DS_W = $clog2(DC_SETS);
  localparam int DW_W = $clog2(DC_WORDS);

  // ---------------------------------------------------------------
  // Arrays
  // ---------------------------------------------------------------
  // No reset on the arrays: software is expected to initialise them through
  // the write operations, as real RAM would need.
  logic [diag_pkg::BTAG_W-1:0] btag_mem [BTB_SETS*BTB_ENTRIES];
  logic [diag_pkg::BTAB_W-1:0] btab_mem [BTB_SETS*BTB_ENTRIES];
  logic [diag_pkg::ITAG_W-1:0] itag_mem [IC_LINES];
  logic [31:0] iword_mem [IC_LINES*IC_WORDS];
  logic [diag_pkg::DTAG_W-1:0] dtag_mem [DC_SETS*DC_ENTRIES];
  logic [31:0] dword_mem [DC_SETS*DC_ENTRIES*DC_WORDS];
  logic [1:0] dflag_mem [DC_SETS*DC_ENTRIES];

  // ---------------------------------------------------------------
  // Index functions
  // ---------------------------------------------------------------
  // Branch buffer index, shared by the tag and target arrays.
  function automatic logic [BS_W+BE_W-1:0] btb_idx(input logic [31:0] b);
    btb_idx = {b[diag_pkg::BTB_SET_LSB +: BS_W], b[diag_pkg::BTB_ENTRY_LSB +: BE_W]};
  endfunction

  // Data cache line index, shared by tag, word and flag arrays.
  function automatic logic [DS_W+DE_W-1:0] dc_idx(input logic [31:0] b);
    dc_idx = {b[diag_pkg::DTAG_SET_LSB +: DS_W], b[diag_pkg::DTAG_ENTRY_LSB +: DE_W]};
  endfunction

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic hit;
  logic allowed;
  logic trap_now;
  diag_pkg::sub_op_t op;
  logic [BS_W+BE_W-1:0] bi;
  logic [IL_W-1:0] il;
  logic [IL_W+IW_W-1:0] iwi;
  logic [DS_W+DE_W-1:0] di;
  logic [DS_W+DE_W+DW_W-1:0] dwi;

  // Recognise the group and gate it on privilege level zero.
  always_comb begin
    op = diag_pkg::sub_op_t'(cmd.sub);
    hit = cmd.valid && (cmd.major == diag_pkg::MAJOR_DIAG) &&
          (cmd.sub >= 6'(diag_pkg::write_branch_tag_op)) &&
          (cmd.sub <= 6'(diag_pkg::read_dcache_word_op));
    trap_now = hit && (cmd.priv != diag_pkg::PRIV_MOST);
    allowed = hit && (cmd.priv == diag_pkg::PRIV_MOST);
  end

  // Array indices from the base register.
  always_comb begin
    bi = btb_idx(cmd.base);
    il = cmd.base[diag_pkg::ITAG_ENTRY_LSB +: IL_W];
    iwi = {cmd.base[diag_pkg::IC_LINE_LSB +: IL_W], cmd.base[diag_pkg::IC_WORD_LSB +: IW_W]};
    di = dc_idx(cmd.base);
    dwi = {di, cmd.base[diag_pkg::IC_WORD_LSB +: DW_W]};
  end

  // ---------------------------------------------------------------
  // Entry assembly
  // ---------------------------------------------------------------
  // The branch tag, branch target and data flag entries are built here, apart from the
  // array writes, so their bit layout reads in one place; the arrays only pick the slot.
  logic [diag_pkg::BTAG_W-1:0] btag_new;
  logic [diag_pkg::BTAB_W-1:0] btab_new;
  logic [diag_pkg::FLAG_W-1:0] dflag_new;

  // The branch tag has no separate source, so software sets its valid and order bits through the base.
  always_comb begin
    btag_new = {cmd.base[diag_pkg::BTAG_SRC_LSB +: diag_pkg::BTAG_TAG_W],
                cmd.base[diag_pkg::BTAG_EXT_LSB +: diag_pkg::BTAG_EXT_W]};
    btab_new = {cmd.src, cmd.src[diag_pkg::FLAG_W-1:0]};
    dflag_new = cmd.base[diag_pkg::DC_FLAG_LSB +: diag_pkg::FLAG_W];
  end

  // ---------------------------------------------------------------
  // Array writes
  // ---------------------------------------------------------------
  // Branch buffer writes.
  always_ff @(posedge clk) begin
    if (allowed && op == diag_pkg::write_branch_tag_op) begin
      btag_mem[bi] <= btag_new;
    end
    if (allowed && op == diag_pkg::write_branch_target_op) begin
      btab_mem[bi] <= btab_new;
    end
  end

  // Instruction cache writes.
  always_ff @(posedge clk) begin
    if (allowed && op == diag_pkg::write_icache_tag_op) begin
      itag_mem[il] <= cmd.base[diag_pkg::ITAG_SRC_LSB +: diag_pkg::ITAG_W];
    end
    if (allowed && op == diag_pkg::write_icache_word_op) begin
      iword_mem[iwi] <= cmd.src;
    end
  end

  // Data cache writes.
  always_ff @(posedge clk) begin
    if (allowed && op == diag_pkg::write_dcache_tag_op) begin
      dtag_mem[di] <= cmd.base[diag_pkg::DTAG_SRC_LSB +: diag_pkg::DTAG_W];
    end
    if (allowed && op == diag_pkg::write_dcache_word_op) begin
      dword_mem[dwi] <= cmd.src;
      dflag_mem[di] <= dflag_new;
    end
  end

  // ---------------------------------------------------------------
  // Read answer
  // ---------------------------------------------------------------
  logic [31:0] rd_data;
  logic [31:0] rd_mask;
  logic is_write;
  logic [diag_pkg::BTAB_W-1:0] btab_e;

  // Select and place the read value; mask tells the register file which bits change.
  // The arrays are read as left by the previous edge; only one instruction
  // arrives per cycle, so a read never races a write to the same slot.
  always_comb begin
    rd_data = 32'h00000000;
    rd_mask = 32'h00000000;
    is_write = 1'b0;
    btab_e = btab_mem[bi];
    case (op)
      diag_pkg::read_branch_tag_op: begin
        rd_data = {btag_mem[bi], 5'h00};
        rd_mask = diag_pkg::MASK_BTAG;
      end
      diag_pkg::read_branch_target_op: begin
        if (cmd.base[diag_pkg::BTB_FIELD_BIT]) begin
          rd_data = {30'h00000000, btab_e[1:0]};
          rd_mask = diag_pkg::MASK_PAIR;
        end else begin
          rd_data = btab_e[diag_pkg::BTAB_W-1:2];
          rd_mask = diag_pkg::MASK_ALL;
        end
      end
      diag_pkg::read_icache_tag_op: begin
        rd_data = {itag_mem[il], 11'h000};
        rd_mask = diag_pkg::MASK_ITAG;
      end
      diag_pkg::read_icache_word_op: begin
        rd_data = iword_mem[iwi];
        rd_mask = diag_pkg::MASK_ALL;
      end
      diag_pkg::read_dcache_tag_op: begin
        rd_data = {dtag_mem[di], 9'h000};
        rd_mask = diag_pkg::MASK_DTAG;
      end
      diag_pkg::read_dcache_word_op: begin
        if (cmd.base[diag_pkg::DC_FIELD_BIT]) begin
          rd_data = {30'h00000000, dflag_mem[di]};
          rd_mask = diag_pkg::MASK_PAIR;
        end else begin
          rd_data = dword_mem[dwi];
          rd_mask = diag_pkg::MASK_ALL;
        end
      end
      default: begin
        is_write = 1'b1;
      end
    endcase
  end

  // Answer register: one cycle after the request, for one cycle.
  // A trap answers with an empty mask, so the destination keeps its old value
  // while the pipeline takes the privilege trap.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rsp <= '0;
    end else begin
      rsp.valid <= hit;
      rsp.trap <= trap_now;
      rsp.mask <= (allowed && !is_write) ? rd_mask : 32'h00000000;
      rsp.data <= (allowed && !is_write) ? rd_data : 32'h00000000;
    end
  end

  // ---------------------------------------------------------------
  // Software registers and interrupt
  // ---------------------------------------------------------------
  logic [diag_pkg::EV_W-1:0] status_q;
  logic [diag_pkg::EV_W-1:0] mask_q;
  logic [diag_pkg::EV_W-1:0] ev;
  logic [diag_pkg::EV_W-1:0] clr;
  logic [31:0] count_q;
  logic [5:0] last_q;

  always_comb begin
    ev = '0;
    ev[diag_pkg::EV_TRAP] = trap_now;
    ev[diag_pkg::EV_WRITE] = allowed && is_write;
    ev[diag_pkg::EV_READ] = allowed && !is_write;
  end

  // Write-one-to-clear vector; only a write to the status word may clear bits.
  always_comb begin
    clr = '0;
    if (reg_wr && reg_addr == diag_pkg::OFS_STATUS) begin
      clr = reg_wdata[diag_pkg::EV_W-1:0];
    end
  end

  // Sticky status, write one to clear; a new event in the same cycle wins.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_q <= diag_pkg::EV_RESET;
    end else begin
      status_q <= (status_q & ~clr) | ev;
    end
  end

  // Mask register.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mask_q <= diag_pkg::EV_RESET;
    end else if (reg_wr && reg_addr == diag_pkg::OFS_MASK) begin
      mask_q <= reg_wdata[diag_pkg::EV_W-1:0];
    end
  end

  // Recognised-instruction counter and last sub-operation, for software visibility.
  // Refused attempts count as well, so software can see privilege misuse.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= 32'h00000000;
      last_q <= 6'h00;
    end else if (hit) begin
      count_q <= count_q + 32'h00000001;
      last_q <= cmd.sub;
    end
  end

  // Read data stands in the cycle after the strobe only; unmapped reads give zero.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 32'h00000000;
    end else if (!reg_rd) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_addr == diag_pkg::OFS_STATUS) begin
      reg_rdata <= {29'h00000000, status_q};
    end else if (reg_addr == diag_pkg::OFS_MASK) begin
      reg_rdata <= {29'h00000000, mask_q};
    end else if (reg_addr == diag_pkg::OFS_COUNT) begin
      reg_rdata <= count_q;
    end else if (reg_addr == diag_pkg::OFS_LAST) begin
      reg_rdata <= {26'h0000000, last_q};
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // Level interrupt from unmasked sticky status.
  assign irq = |(status_q & mask_q);

endmodule

`default_nettype wire

// ===== rtl/diag_pkg.sv
// Constants and carrier types for the cache and branch buffer diagnostic access unit.
// Assumes a big-endian register view: instruction-set bit n of a word is vector bit 31-n.
package diag_pkg;

  // Instruction recognition.
  localparam logic [5:0] MAJOR_DIAG = 6'h05;
  localparam logic [1:0] PRIV_MOST = 2'h0;

  typedef enum logic [5:0] {
    write_branch_tag_op    = 6'h04,
    read_branch_tag_op     = 6'h05,
    write_branch_target_op = 6'h06,
    read_branch_target_op  = 6'h07,
    write_icache_tag_op    = 6'h08,
    read_icache_tag_op     = 6'h09,
    write_icache_word_op   = 6'h0A,
    read_icache_word_op    = 6'h0B,
    write_dcache_tag_op    = 6'h0C,
    read_dcache_tag_op     = 6'h0D,
    write_dcache_word_op   = 6'h0E,
    read_dcache_word_op    = 6'h0F
  } sub_op_t;

  // Base register fields, little-endian vector positions.
  localparam int BTB_ENTRY_LSB = 0;
  localparam int BTB_SET_LSB = 6;
  localparam int BTB_FIELD_BIT = 8;
  localparam int BTAG_SRC_LSB = 8;
  localparam int BTAG_EXT_LSB = 8;
  localparam int ITAG_ENTRY_LSB = 0;
  localparam int ITAG_SRC_LSB = 11;
  localparam int IC_LINE_LSB = 4;
  localparam int IC_WORD_LSB = 2;
  localparam int DTAG_ENTRY_LSB = 4;
  localparam int DTAG_SET_LSB = 0;
  localparam int DTAG_SRC_LSB = 9;
  localparam int DC_FLAG_LSB = 10;
  localparam int DC_FIELD_BIT = 10;

  // Entry widths and result placement.
  localparam int BTAG_W = 27;
  localparam int BTAB_W = 34;
  localparam int ITAG_W = 21;
  localparam int DTAG_W = 23;
  localparam int BTAG_RES_LSB = 5;
  localparam int BTAG_TAG_W = 24;
  localparam int BTAG_EXT_W = 3;
  localparam int FLAG_W = 2;
  localparam logic [31:0] MASK_ALL = 32'hFFFFFFFF;
  localparam logic [31:0] MASK_BTAG = 32'hFFFFFFE0;
  localparam logic [31:0] MASK_ITAG = 32'hFFFFF800;
  localparam logic [31:0] MASK_DTAG = 32'hFFFFFE00;
  localparam logic [31:0] MASK_PAIR = 32'h00000003;

  // Software register map and event bits.
  localparam logic [3:0] OFS_STATUS = 4'h0;
  localparam logic [3:0] OFS_MASK = 4'h4;
  localparam logic [3:0] OFS_COUNT = 4'h8;
  localparam logic [3:0] OFS_LAST = 4'hC;
  localparam int EV_W = 3;
  localparam int EV_TRAP = 0;
  localparam int EV_WRITE = 1;
  localparam int EV_READ = 2;
  localparam logic [EV_W-1:0] EV_RESET = 3'h0;

  typedef struct packed {
    logic valid;
    logic [5:0] major;
    logic [5:0] sub;
    logic [1:0] priv;
    logic [31:0] base;
    logic [31:0] src;
  } cmd_t;

  typedef struct packed {
    logic valid;
    logic trap;
    logic [31:0] mask;
    logic [31:0] data;
  } rsp_t;

endpackage

// ===== bench/diag_access_chk.sv
// Port-level checker for the diagnostic access unit.
// Assumes it is bound to diag_access and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module diag_access_chk (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Instruction port.
  input wire diag_pkg::cmd_t cmd,
  input wire diag_pkg::rsp_t rsp,
  // Software port and interrupt.
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic irq
);
  // ----------------------------------------
  // Request decode
  // ----------------------------------------
  logic rec;
  logic ok;
  logic [5:0] op;
  // Only a privileged request may reach the arrays, so op is zero otherwise.
  assign rec = cmd.valid && cmd.major == diag_pkg::MAJOR_DIAG && cmd.sub >= 6'h04 && cmd.sub <= 6'h0F;
  assign ok = rec && cmd.priv == 2'h0;
  assign op = ok ? cmd.sub : 6'h00;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  a_answer_next: assert property (rec |=> rsp.valid)
    else $error("No answer after a request.");
  a_foreign_quiet: assert property (!rec |=> !rsp.valid)
    else $error("Answer without a request.");
  a_trap_priv: assert property (rec && cmd.priv != 2'h0 |=> rsp.trap && rsp.mask == 32'h0)
    else $error("Lower level not trapped.");
  a_write_nomask: assert property (ok && !cmd.sub[0] |=> !rsp.trap && rsp.mask == 32'h0)
    else $error("Write changed the destination.");
  a_btag_mask: assert property (op == 6'h05 |=> rsp.mask == diag_pkg::MASK_BTAG)
    else $error("Branch tag read mask wrong.");
  a_btab_field: assert property (op == 6'h07 |=>
    rsp.mask == ($past(cmd.base[8]) ? diag_pkg::MASK_PAIR : diag_pkg::MASK_ALL)) else $error("Target field wrong.");
  a_itag_mask: assert property (op == 6'h09 |=> rsp.mask == diag_pkg::MASK_ITAG)
    else $error("Instruction tag mask wrong.");
  a_dtag_mask: assert property (op == 6'h0D |=> rsp.mask == diag_pkg::MASK_DTAG)
    else $error("Data tag mask wrong.");
  a_dword_field: assert property (op == 6'h0F |=>
    rsp.mask == ($past(cmd.base[10]) ? diag_pkg::MASK_PAIR : diag_pkg::MASK_ALL)) else $error("Data field wrong.");
  a_btag_loop: assert property (op == 6'h05 && $past(op) == 6'h04 && $past(cmd.base[7:0]) == cmd.base[7:0] |=>
    rsp.data == {$past(cmd.base[31:8], 2), $past(cmd.base[10:8], 2), 5'h00}) else $error("Branch tag lost.");
endmodule
`default_nettype wire

// ===== bench/diag_model.sv
// Decoder and register file model facing the diagnostic access unit.
// Assumes the bench raises go for one cycle per instruction.
`timescale 1ns/100ps
`default_nettype none
module diag_model (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Instruction fields from the bench.
  input wire logic go,
  input wire logic [5:0] major,
  input wire logic [5:0] sub,
  input wire logic [1:0] priv,
  input wire logic [31:0] base,
  input wire logic [31:0] src,
  // Unit side.
  output var diag_pkg::cmd_t cmd,
  input wire diag_pkg::rsp_t rsp,
  // Destination register.
  output logic [31:0] dest_q
);
  // ----------------------------------------
  // Decode and write-back
  // ----------------------------------------
  // The decoder issues the fields it holds in the cycle of the request.
  assign cmd = {go, major, sub, priv, base, src};
  // masked merge only
  // Bits outside the mask keep their old value, so partial reads are visible.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dest_q <= 32'hFFFFFFFF;
    end else if (rsp.valid && !rsp.trap) begin
      dest_q <= (dest_q & ~rsp.mask) | (rsp.data & rsp.mask);
    end
  end
endmodule
`default_nettype wire

// ===== bench/tb_diag_access.sv
// Bench for the diagnostic access unit: instruction bursts and software port.
// Assumes diag_model drives the unit and the checker is bound below.
`timescale 1ns/100ps
`default_nettype none
module tb_diag_access;
  localparam logic [5:0] M = diag_pkg::MAJOR_DIAG;
  localparam logic [31:0] Z = 32'h0;
  localparam logic [31:0] F = 32'hFFFFFFFF;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic go = 1'b0;
  logic [5:0] mj = 6'h00;
  logic [5:0] sb = 6'h00;
  logic [1:0] pv = 2'h0;
  logic [31:0] b = 32'h0;
  logic [31:0] s = 32'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, dest_q, e_m, e_d;
  logic [31:0] nrec = 32'h0;
  logic [31:0] last = 32'h0;
  logic irq, e_v, e_t;
  logic pend = 1'b0;
  diag_pkg::cmd_t cmd;
  diag_pkg::rsp_t rsp;
  int mismatches = 0;
  int total_checks = 0;
  int i;
  // ----------------------------------------
  // Clock, model and unit
  // ----------------------------------------
  always #4 clk = ~clk;
  diag_model model_u (.clk(clk), .rstn(rstn), .go(go), .major(mj), .sub(sb), .priv(pv), .base(b), .src(s),
    .cmd(cmd), .rsp(rsp), .dest_q(dest_q));
  diag_access dut_u (.clk(clk), .rstn(rstn), .cmd(cmd), .rsp(rsp), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  // Runs are back to back: go stays high between calls and drops only in idle.
  task automatic run(input logic [5:0] j, input logic [5:0] u, input logic [1:0] p, input logic [31:0] bv,
    input logic [31:0] sv, input logic [31:0] m, input logic [31:0] d);
    go <= 1'b1;
    mj <= j;
    sb <= u;
    pv <= p;
    b <= bv;
    s <= sv;
    @(posedge clk);
    e_v = (j == M) && (u >= 6'h04) && (u <= 6'h0F);
    e_t = (p != 2'h0);
    e_m = m;
    e_d = d;
    pend = 1'b1;
    if (e_v) begin
      nrec = nrec + 32'h1;
      last = {26'h0, u};
    end
  endtask
  task automatic idle;
    go <= 1'b0;
    @(posedge clk);
  endtask
  // The answer stands for one cycle, so it is looked at mid-cycle.
  always @(negedge clk) begin
    if (pend) begin
      pend = 1'b0;
      chk(rsp.valid, e_v);
      if (e_v) begin
        chk(rsp.trap, e_t);
        chk(rsp.mask, e_m);
        chk(rsp.data, e_d);
      end
    end
  end
  task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] wd, input logic [31:0] e);
    reg_wr <= w;
    reg_rd <= !w;
    reg_addr <= a;
    reg_wdata <= wd;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    @(negedge clk);
    if (!w) chk(reg_rdata, e);
    @(posedge clk);
  endtask
  task automatic finish_test;
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Main sequence: arrays first, then status, mask and interrupt.
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    run(M, 6'h04, 2'h0, 32'h11111143, Z, Z, Z);
    run(M, 6'h04, 2'h0, 32'hABCDE5C3, Z, Z, Z);
    run(M, 6'h05, 2'h0, 32'h000000C3, Z, diag_pkg::MASK_BTAG, 32'hABCDE5A0);
    run(M, 6'h05, 2'h0, 32'h00000043, Z, diag_pkg::MASK_BTAG, 32'h11111120);
    run(M, 6'h06, 2'h0, 32'h000000C3, 32'hDEADBEE6, Z, Z);
    run(M, 6'h07, 2'h0, 32'h000001C3, Z, 32'h3, 32'h2);
    idle;
    @(negedge clk);
    chk(dest_q, 32'h1111113E);
    @(posedge clk);
    run(M, 6'h07, 2'h0, 32'h000000C3, Z, F, 32'hDEADBEE6);
    run(M, 6'h08, 2'h0, 32'h12345A5A, Z, Z, Z);
    run(M, 6'h09, 2'h0, 32'h0000005A, Z, diag_pkg::MASK_ITAG, 32'h12345800);
    run(M, 6'h0A, 2'h0, 32'h00000A54, 32'hCAFEF00D, Z, Z);
    run(M, 6'h0A, 2'h0, 32'h00000A58, 32'h0BADC0DE, Z, Z);
    run(M, 6'h0B, 2'h0, 32'h00000A58, Z, F, 32'h0BADC0DE);
    run(M, 6'h0B, 2'h0, 32'h00000A54, Z, F, 32'hCAFEF00D);
    run(M, 6'h0C, 2'h0, 32'h87654321, Z, Z, Z);
    run(M, 6'h0C, 2'h0, 32'h0F0F0322, Z, Z, Z);
    run(M, 6'h0D, 2'h0, 32'h00000321, Z, diag_pkg::MASK_DTAG, 32'h87654200);
    run(M, 6'h0D, 2'h0, 32'h00000322, Z, diag_pkg::MASK_DTAG, 32'h0F0F0200);
    run(M, 6'h0E, 2'h0, 32'h00000B25, 32'h13572468, Z, Z);
    run(M, 6'h0F, 2'h0, 32'h00000325, Z, F, 32'h13572468);
    run(M, 6'h0F, 2'h0, 32'h00000725, Z, 32'h3, 32'h2);
    for (i = 4; i < 16; i++) begin
      run(M, 6'(i), 2'(i % 3 + 1), 32'h00000A54, Z, Z, Z);
    end
    run(M, 6'h0B, 2'h0, 32'h00000A54, Z, F, 32'hCAFEF00D);
    run(6'h06, 6'h0B, 2'h0, 32'h00000A54, Z, Z, Z);
    run(M, 6'h03, 2'h0, Z, Z, Z, Z);
    run(M, 6'h10, 2'h0, Z, Z, Z, Z);
    idle;
    acc(1'b0, diag_pkg::OFS_STATUS, Z, 32'h7);
    chk(irq, Z);
    acc(1'b0, diag_pkg::OFS_COUNT, Z, nrec);
    acc(1'b0, diag_pkg::OFS_LAST, Z, last);
    acc(1'b1, diag_pkg::OFS_COUNT, Z, Z);
    acc(1'b0, diag_pkg::OFS_COUNT, Z, nrec);
    acc(1'b0, 4'h2, Z, Z);
    acc(1'b1, diag_pkg::OFS_MASK, 32'h1, Z);
    chk(irq, 32'h1);
    acc(1'b1, diag_pkg::OFS_STATUS, 32'h1, Z);
    chk(irq, Z);
    acc(1'b0, diag_pkg::OFS_STATUS, Z, 32'h6);
    acc(1'b1, diag_pkg::OFS_MASK, 32'h6, Z);
    chk(irq, 32'h1);
    acc(1'b1, diag_pkg::OFS_STATUS, 32'h6, Z);
    chk(irq, Z);
    acc(1'b0, diag_pkg::OFS_STATUS, Z, Z);
    finish_test;
  end
  // A hang costs far more than the roughly 70 cycles the sequence needs.
  initial begin
    #20000;
    mismatches++;
    finish_test;
  end
endmodule
bind diag_access diag_access_chk chk_u (.clk(clk), .rstn(rstn), .cmd(cmd), .rsp(rsp), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq));
`default_nettype wire
